// ### hardware_config_register.sv
// hardware_config_register: APB register bank for the hardware configuration word
// assumes a single 125 MHz clock, async active-high reset, strap held stable at power-up
//
// Summary of operation
// [RULE1] software stops transmit and receive before writing this register.
// [RULE2] bit 24 is read-only and shows the strap level caught after reset.
// [RULE3] software writes one to bit 20 for normal operation although it resets to zero.
// [RULE4] bits 19:16 set the transmit allocation in kilobytes, at most fourteen, reset five.
// [RULE5] the transmit status FIFO always gets 512 bytes of the transmit allocation; fifoSplit reads zero during reset and until the first clock after release.
// [RULE6] software never programs a transmit allocation below two kilobytes.
// [RULE7] the transmit data FIFO, holding payload and commands, gets the rest of it.
// [RULE8] the receive FIFOs share sixteen kilobytes minus the transmit allocation.
// [RULE9] bits 6:5 pick the MII clock source: internal, external, stopped, internal; reset 00.
// [RULE10] the clock source field moves only the MII receive and transmit clocks.
// [RULE11] bit 4 sends management traffic to the internal PHY at zero, external at one.
// [RULE12] with bit 4 set the internal MDIO and MDC are driven low.
// [RULE13] with bit 4 clear the external MDIO is released and external MDC is low.
// [RULE14] bit 4 is independent of the MII port enable and touches only MDIO and MDC.
// [RULE15] bit 2 enables the external MII port; zero selects the internal PHY.
// [RULE16] reserved bits read zero and ignore writes.
//
// The APB register port was left to the implementer.
`timescale 1ns/1ns
module hardware_config_register
   import hw_config_pkg::*;
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic autoCrossoverStrapPin,
   input wire logic mdc,
   input wire logic mdioOut,
   input wire logic mdioOe,
   output mgmt_pins_t mgmtPins,
   output fifo_split_t fifoSplit,
   output clk_source_t miiClockSource,
   output logic miiClockEnable,
   output logic externalMiiPortEnable,
   output logic mandatoryOneBit
);
   // ----------------------------------------
   // storage
   // ----------------------------------------
   logic [1:0] strapSync_reg;
   logic [1:0] strapValid_reg;
   logic strapCaught_reg;
   logic auto_crossover_strap_reg;
   logic mandatory_one_bit_reg;
   logic [3:0] transmit_buffer_allocation_reg;
   logic [1:0] mii_clock_source_select_reg;
   logic management_port_select_reg;
   logic external_mii_port_enable_reg;
   logic [31:0] hardware_configuration;
   logic [3:0] allocNext;
   logic access;
   logic hit;
   mgmt_pins_t mgmtNext;
   fifo_split_t splitNext;
   clk_source_t clkNext;

   assign access = psel && penable;
   assign hit = paddr == HW_CONFIG_OFFSET;

   // ----------------------------------------
   // strap capture
   // ----------------------------------------
   // strap synchroniser; second stage is the only reader of the first
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         strapSync_reg <= 2'h0;
      end else begin
         strapSync_reg <= {strapSync_reg[0], autoCrossoverStrapPin};
      end
   end

   // fill marker: the strap is trusted only once both synchroniser stages hold it
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         strapValid_reg <= 2'h0;
      end else begin
         strapValid_reg <= {strapValid_reg[0], 1'b1};
      end
   end

   // catch the strap once after release and hold it read-only
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         strapCaught_reg <= 1'b0;
         auto_crossover_strap_reg <= 1'b0;
      end else if (!strapCaught_reg && strapValid_reg[1]) begin
         strapCaught_reg <= 1'b1;
         auto_crossover_strap_reg <= strapSync_reg[1]; // RULE2
      end
   end

   // ----------------------------------------
   // writable fields
   // ----------------------------------------
   // clamp allocation to fourteen kilobytes; smaller-than-two is software's duty
   always_comb begin
      allocNext = pwdata[ALLOC_LSB +: 4];
      if (allocNext > ALLOC_MAX_KB) begin
         allocNext = ALLOC_MAX_KB; // RULE4
      end
   end

   // register writes land at the access edge; reserved bits are dropped
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         mandatory_one_bit_reg <= 1'b0; // RULE3
         transmit_buffer_allocation_reg <= ALLOC_RESET; // RULE4
         mii_clock_source_select_reg <= 2'h0; // RULE9
         management_port_select_reg <= 1'b0; // RULE11
         external_mii_port_enable_reg <= 1'b0; // RULE15
      end else if (access && pwrite && hit) begin // RULE1 RULE16
         mandatory_one_bit_reg <= pwdata[ONE_BIT];
         transmit_buffer_allocation_reg <= allocNext; // RULE4 RULE6
         mii_clock_source_select_reg <= pwdata[CLKSEL_LSB +: 2]; // RULE9
         management_port_select_reg <= pwdata[MGMT_BIT]; // RULE11 RULE14
         external_mii_port_enable_reg <= pwdata[EXTEN_BIT]; // RULE15
      end
   end

   // ----------------------------------------
   // read view
   // ----------------------------------------
   always_comb begin
      hardware_configuration = '0; // RULE16
      hardware_configuration[STRAP_BIT] = auto_crossover_strap_reg; // RULE2
      hardware_configuration[ONE_BIT] = mandatory_one_bit_reg;
      hardware_configuration[ALLOC_LSB +: 4] = transmit_buffer_allocation_reg;
      hardware_configuration[CLKSEL_LSB +: 2] = mii_clock_source_select_reg;
      hardware_configuration[MGMT_BIT] = management_port_select_reg;
      hardware_configuration[EXTEN_BIT] = external_mii_port_enable_reg;
   end

   // APB answer: zero wait states, unmapped reads zero with an error flag
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !hit;
         prdata <= (psel && !penable && hit && !pwrite) ? hardware_configuration
                   : 32'h00000000;
      end
   end

   // ----------------------------------------
   // derived controls
   // ----------------------------------------
   // clock source decode; 11 aliases the internal PHY
   always_comb begin
      case (mii_clock_source_select_reg) // RULE9 RULE10
         2'h0: clkNext = CLK_INTERNAL;
         2'h1: clkNext = CLK_EXTERNAL;
         2'h2: clkNext = CLK_STOPPED;
         2'h3: clkNext = CLK_INTERNAL;
         default: clkNext = CLK_INTERNAL;
      endcase
   end

   fifo_split u_split (
      .allocKb(transmit_buffer_allocation_reg),
      .split(splitNext)
   );

   mgmt_route u_route (
      .selExternal(management_port_select_reg),
      .mdc(mdc),
      .mdioOut(mdioOut),
      .mdioOe(mdioOe),
      .pins(mgmtNext)
   );

   // registered outputs; fifo sizes, clocks and management stay separate concerns
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         mgmtPins <= '0;
         fifoSplit <= '0;
         miiClockSource <= CLK_INTERNAL;
         miiClockEnable <= 1'b1;
         externalMiiPortEnable <= 1'b0;
         mandatoryOneBit <= 1'b0;
      end else begin
         mgmtPins <= mgmtNext; // RULE12 RULE13 RULE14
         fifoSplit <= splitNext; // RULE5 RULE7 RULE8
         miiClockSource <= clkNext; // RULE10
         miiClockEnable <= clkNext != CLK_STOPPED; // RULE9
         externalMiiPortEnable <= external_mii_port_enable_reg; // RULE15
         mandatoryOneBit <= mandatory_one_bit_reg; // RULE3
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   a_strap_readonly: assert property (@(posedge clock) disable iff (sys_rst) // RULE2
      strapCaught_reg |=> $stable(auto_crossover_strap_reg))
      else $error("strap bit changed after capture");
   a_alloc_max: assert property (@(posedge clock) disable iff (sys_rst) // RULE4
      transmit_buffer_allocation_reg <= ALLOC_MAX_KB)
      else $error("allocation above fourteen kilobytes");
   a_status_fixed: assert property (@(posedge clock) disable iff (sys_rst) // RULE5
      !$past(sys_rst) |-> fifoSplit.txStatusBytes == STATUS_BYTES)
      else $error("status fifo not 512 bytes");
   a_split_total: assert property (@(posedge clock) disable iff (sys_rst) // RULE8
      !$past(sys_rst) |-> fifoSplit.txStatusBytes + fifoSplit.txDataBytes
         + fifoSplit.rxBytes == TOTAL_BYTES)
      else $error("fifo split does not sum to sixteen kilobytes");
   a_clock_stop: assert property (@(posedge clock) disable iff (sys_rst) // RULE9
      mii_clock_source_select_reg == 2'h2 |=> !miiClockEnable)
      else $error("clocks not stopped");
   a_internal_low: assert property (@(posedge clock) disable iff (sys_rst) // RULE12
      management_port_select_reg |=> !mgmtPins.intMdc && !mgmtPins.intMdioOut
         && mgmtPins.intMdioOe)
      else $error("internal management lines not low");
   a_external_idle: assert property (@(posedge clock) disable iff (sys_rst) // RULE13
      !management_port_select_reg |=> !mgmtPins.extMdioOe && !mgmtPins.extMdc)
      else $error("external management lines not idle");
   a_write_lands: assert property (@(posedge clock) disable iff (sys_rst) // RULE11
      access && pwrite && hit |=> management_port_select_reg == $past(pwdata[MGMT_BIT]))
      else $error("management select write lost");
   a_enable_follows: assert property (@(posedge clock) disable iff (sys_rst) // RULE15
      ##1 externalMiiPortEnable == $past(external_mii_port_enable_reg))
      else $error("port enable output stale");

   // bus answer, error flag and reserved space
   a_ready_answer: assert property (@(posedge clock) disable iff (sys_rst) // RULE16
      psel && !penable |=> pready)
      else $error("no ready in access phase");
   a_ready_pulse: assert property (@(posedge clock) disable iff (sys_rst) // RULE16
      pready |=> !pready)
      else $error("ready held longer than one cycle");
   a_unmapped_error: assert property (@(posedge clock) disable iff (sys_rst) // RULE16
      psel && !penable && !hit |=> pslverr)
      else $error("unmapped access without error flag");
   a_mapped_clean: assert property (@(posedge clock) disable iff (sys_rst) // RULE16
      psel && !penable && hit |=> !pslverr)
      else $error("error flag on mapped access");
   a_unmapped_zero: assert property (@(posedge clock) disable iff (sys_rst) // RULE16
      psel && !penable && !hit |=> prdata == 32'h00000000)
      else $error("unmapped read not zero");
   a_read_word: assert property (@(posedge clock) disable iff (sys_rst) // RULE2
      psel && !penable && hit && !pwrite |=> prdata == $past(hardware_configuration))
      else $error("read word not presented");
   a_reserved_zero: assert property (@(posedge clock) disable iff (sys_rst) // RULE16
      pready |-> (prdata & ~(WRITE_MASK | (32'h00000001 << STRAP_BIT))) == 32'h00000000)
      else $error("reserved bits not zero");
   a_write_ignored: assert property (@(posedge clock) disable iff (sys_rst) // RULE16
      access && pwrite && !hit |=> $stable(hardware_configuration[STRAP_BIT-1:0]))
      else $error("unmapped write changed the register");

   // strap capture
   a_strap_capture: assert property (@(posedge clock) disable iff (sys_rst) // RULE2
      !strapCaught_reg && strapValid_reg[1] |=> auto_crossover_strap_reg == $past(strapSync_reg[1]))
      else $error("strap not taken from synchroniser");
   a_strap_wait: assert property (@(posedge clock) disable iff (sys_rst) // RULE2
      !strapValid_reg[1] |=> !strapCaught_reg)
      else $error("strap taken before synchroniser filled");

   // writable fields and their outputs
   a_one_lands: assert property (@(posedge clock) disable iff (sys_rst) // RULE3
      access && pwrite && hit |=> mandatory_one_bit_reg == $past(pwdata[ONE_BIT]))
      else $error("mandatory one write lost");
   a_one_follows: assert property (@(posedge clock) disable iff (sys_rst) // RULE3
      1'b1 |=> mandatoryOneBit == $past(mandatory_one_bit_reg))
      else $error("mandatory one output stale");
   a_alloc_write: assert property (@(posedge clock) disable iff (sys_rst) // RULE4
      access && pwrite && hit && pwdata[ALLOC_LSB +: 4] <= ALLOC_MAX_KB
         |=> transmit_buffer_allocation_reg == $past(pwdata[ALLOC_LSB +: 4]))
      else $error("allocation write lost");
   a_alloc_clamp: assert property (@(posedge clock) disable iff (sys_rst) // RULE4
      access && pwrite && hit && pwdata[ALLOC_LSB +: 4] > ALLOC_MAX_KB
         |=> transmit_buffer_allocation_reg == ALLOC_MAX_KB)
      else $error("allocation not clamped");
   a_data_fifo: assert property (@(posedge clock) disable iff (sys_rst) // RULE5 RULE7
      !$past(sys_rst) |-> fifoSplit.txDataBytes
         == 15'({11'h000, $past(transmit_buffer_allocation_reg)} * KB_BYTES) - STATUS_BYTES)
      else $error("transmit data fifo size wrong");
   a_rx_space: assert property (@(posedge clock) disable iff (sys_rst) // RULE8
      !$past(sys_rst) |-> fifoSplit.rxBytes
         == TOTAL_BYTES - 15'({11'h000, $past(transmit_buffer_allocation_reg)} * KB_BYTES))
      else $error("receive space wrong");
   a_clock_external: assert property (@(posedge clock) disable iff (sys_rst) // RULE9
      mii_clock_source_select_reg == 2'h1 |=> miiClockSource == CLK_EXTERNAL && miiClockEnable)
      else $error("external clock source not selected");
   a_clock_internal: assert property (@(posedge clock) disable iff (sys_rst) // RULE9
      mii_clock_source_select_reg == 2'h0 || mii_clock_source_select_reg == 2'h3
         |=> miiClockSource == CLK_INTERNAL && miiClockEnable)
      else $error("internal clock source not selected");
   a_clock_stopped: assert property (@(posedge clock) disable iff (sys_rst) // RULE9
      mii_clock_source_select_reg == 2'h2 |=> miiClockSource == CLK_STOPPED)
      else $error("stopped source not shown");
   a_clksel_hold: assert property (@(posedge clock) disable iff (sys_rst) // RULE10
      !(access && pwrite && hit) |=> $stable(mii_clock_source_select_reg))
      else $error("clock source moved without a write");
   a_port_enable_lands: assert property (@(posedge clock) disable iff (sys_rst) // RULE15
      access && pwrite && hit |=> external_mii_port_enable_reg == $past(pwdata[EXTEN_BIT]))
      else $error("port enable write lost");

   // management routing
   a_mgmt_hold: assert property (@(posedge clock) disable iff (sys_rst) // RULE14
      !(access && pwrite && hit) |=> $stable(management_port_select_reg))
      else $error("management select moved without a write");
   a_ext_follows: assert property (@(posedge clock) disable iff (sys_rst) // RULE11
      management_port_select_reg && !$past(sys_rst) |=> mgmtPins.extMdc == $past(mdc)
         && mgmtPins.extMdioOut == $past(mdioOut) && mgmtPins.extMdioOe == $past(mdioOe))
      else $error("external management lines not routed");
   a_int_follows: assert property (@(posedge clock) disable iff (sys_rst) // RULE11
      !management_port_select_reg && !$past(sys_rst) |=> mgmtPins.intMdc == $past(mdc)
         && mgmtPins.intMdioOut == $past(mdioOut) && mgmtPins.intMdioOe == $past(mdioOe))
      else $error("internal management lines not routed");
endmodule : hardware_config_register

// ### hw_config_pkg.sv
// hardware configuration register bank: shared constants and carrier types
// assumes a 32-bit register word reached over APB
package hw_config_pkg;
   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [11:0] HW_CONFIG_OFFSET = 12'h074;
   localparam logic [11:0] RESERVED_HOLE = 12'h000;
   localparam logic [31:0] WRITE_MASK = 32'h001F0074;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int STRAP_BIT = 24;
   localparam int ONE_BIT = 20;
   localparam int ALLOC_LSB = 16;
   localparam int CLKSEL_LSB = 5;
   localparam int MGMT_BIT = 4;
   localparam int EXTEN_BIT = 2;
   // ----------------------------------------
   // reset values, allocation limit (in kilobytes) and sizes (in bytes)
   // ----------------------------------------
   localparam logic [3:0] ALLOC_RESET = 4'h5;
   localparam logic [3:0] ALLOC_MAX_KB = 4'hE;
   localparam logic [14:0] TOTAL_BYTES = 15'h4000;
   localparam logic [14:0] STATUS_BYTES = 15'h0200;
   localparam logic [14:0] KB_BYTES = 15'h0400;
   typedef enum logic [1:0] {CLK_INTERNAL, CLK_EXTERNAL, CLK_STOPPED} clk_source_t;
   typedef struct packed {
      logic [14:0] txStatusBytes;
      logic [14:0] txDataBytes;
      logic [14:0] rxBytes;
   } fifo_split_t;
   typedef struct packed {
      logic intMdc;
      logic intMdioOut;
      logic intMdioOe;
      logic extMdc;
      logic extMdioOut;
      logic extMdioOe;
   } mgmt_pins_t;
endpackage : hw_config_pkg

// ### fifo_split.sv
// fifo_split: turns the transmit allocation field into byte sizes
// assumes field already clamped by the register bank
`timescale 1ns/1ns
module fifo_split
   import hw_config_pkg::*;
(
   input wire logic [3:0] allocKb,
   output fifo_split_t split
);
   // ----------------------------------------
   // sizes
   // ----------------------------------------
   logic [14:0] txBytes;
   // one kilobyte per step of the field
   always_comb begin
      txBytes = 15'({11'h000, allocKb} * KB_BYTES);
      split.txStatusBytes = STATUS_BYTES; // RULE5
      split.txDataBytes = txBytes - STATUS_BYTES; // RULE5 RULE7
      split.rxBytes = TOTAL_BYTES - txBytes; // RULE8
   end
endmodule : fifo_split

// ### mgmt_route.sv
// mgmt_route: steers MDIO/MDC between internal and external PHY
// assumes the select and serial signals are on the local clock
`timescale 1ns/1ns
module mgmt_route
   import hw_config_pkg::*;
(
   input wire logic selExternal,
   input wire logic mdc,
   input wire logic mdioOut,
   input wire logic mdioOe,
   output mgmt_pins_t pins
);
   // ----------------------------------------
   // routing, independent of the MII port enable
   // ----------------------------------------
   always_comb begin
      pins = '0; // idle side sits low, external mdio released
      if (selExternal) begin // RULE11 RULE12
         pins.intMdioOe = 1'b1; // internal line actively held low, never left floating
         pins.extMdc = mdc;
         pins.extMdioOut = mdioOut;
         pins.extMdioOe = mdioOe;
      end else begin // RULE11 RULE13
         pins.intMdc = mdc;
         pins.intMdioOut = mdioOut;
         pins.intMdioOe = mdioOe;
      end
   end
endmodule : mgmt_route

// ### mii_phy_model.sv
// mii_phy_model: far-side PHY pair as seen through the management pins
// assumes pins come straight from the register bank, one clock
`timescale 1ns/1ns
module mii_phy_model
   import hw_config_pkg::*;
(
   input wire logic clock,
   input wire mgmt_pins_t pins,
   output logic extMdioLevel,
   output logic intMdioLevel
);
   logic phyMdio = 1'b0; // phy-side answer, changes every cycle
   // a released internal line shows a moving pattern, never a stale value
   always_ff @(posedge clock) begin
      phyMdio <= ~phyMdio;
   end
   // external mdio has its pull-up, so a released pin reads one
   assign extMdioLevel = pins.extMdioOe ? pins.extMdioOut : 1'b1;
   // internal mdio has no pull
   assign intMdioLevel = pins.intMdioOe ? pins.intMdioOut : phyMdio;
endmodule : mii_phy_model

// ### hardware_config_register_test.sv
// hardware_config_register_test: random and corner APB traffic on the config word
// assumes the package, design files and phy model are compiled first
`timescale 1ns/1ns
module hardware_config_register_test;
   import hw_config_pkg::*;
   logic clock = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd, d;
   logic pready, pslverr, err, strap = 1'b1, capS, mdc = 1'b0, mdioOut = 1'b0, mdioOe = 1'b0;
   logic miiClockEnable, externalMiiPortEnable, mandatoryOneBit, extMdioLevel, intMdioLevel;
   mgmt_pins_t mgmtPins;
   fifo_split_t fifoSplit;
   clk_source_t miiClockSource;
   int err_total = 0, compares = 0, cyc = 0, seed = 32'h53B5;
   hardware_config_register hardware_config_register_inst (.clock(clock), .sys_rst(sys_rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .autoCrossoverStrapPin(strap),
      .mdc(mdc), .mdioOut(mdioOut), .mdioOe(mdioOe), .mgmtPins(mgmtPins),
      .fifoSplit(fifoSplit), .miiClockSource(miiClockSource), .miiClockEnable(miiClockEnable),
      .externalMiiPortEnable(externalMiiPortEnable), .mandatoryOneBit(mandatoryOneBit));
   mii_phy_model mii_phy_model_inst (.clock(clock), .pins(mgmtPins),
      .extMdioLevel(extMdioLevel), .intMdioLevel(intMdioLevel));
   // free-running 125 MHz clock
   initial begin
      forever #4 clock = ~clock;
   end
   // mismatch report and count
   task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic test_done();
      $display("errors %0d compares %0d", err_total, compares);
      if (err_total == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : test_done
   // one APB transfer; request held until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // expected read word: writable fields kept, allocation clamped, strap on top
   function automatic logic [31:0] expWord(input logic [31:0] w);
      logic [31:0] e;
      e = w & WRITE_MASK;
      if (w[19:16] > ALLOC_MAX_KB) e[19:16] = ALLOC_MAX_KB;
      e[STRAP_BIT] = capS;
      return e;
   endfunction : expWord
   function automatic fifo_split_t expSplit(input logic [3:0] a);
      fifo_split_t f;
      f.txStatusBytes = STATUS_BYTES;
      f.txDataBytes = a * KB_BYTES - STATUS_BYTES;
      f.rxBytes = TOTAL_BYTES - a * KB_BYTES;
      return f;
   endfunction : expSplit
   // read back and check every derived output against last written word
   task automatic checkAll(input logic [31:0] w);
      logic [31:0] e;
      logic s;
      logic [5:0] m;
      e = expWord(w);
      s = e[MGMT_BIT];
      mdc <= 1'($random(seed));
      mdioOut <= 1'($random(seed));
      mdioOe <= 1'($random(seed));
      apb(1'b0, HW_CONFIG_OFFSET, 32'h0);
      chk(rd, e);
      chk(err, 1'b0);
      chk(fifoSplit, expSplit(e[19:16]));
      chk(miiClockSource, e[6:5] == 2'b01 ? CLK_EXTERNAL : e[6:5] == 2'b10 ? CLK_STOPPED
         : CLK_INTERNAL);
      chk(miiClockEnable, e[6:5] != 2'b10);
      chk(externalMiiPortEnable, e[EXTEN_BIT]);
      chk(mandatoryOneBit, e[ONE_BIT]);
      m = s ? {3'b001, mdc, mdioOut, mdioOe} : {mdc, mdioOut, mdioOe, 3'b000};
      chk(mgmtPins, m);
      if (s || mdioOe) chk(intMdioLevel, !s & mdioOut);
      chk(extMdioLevel, (s & mdioOe) ? mdioOut : 1'b1);
   endtask : checkAll
   // writes happen only with traffic idle, bit 20 set, allocation of 2 KB or more
   task automatic wrCheck(input logic [31:0] w);
      apb(1'b1, HW_CONFIG_OFFSET, w);
      chk(err, 1'b0);
      checkAll(w);
   endtask : wrCheck
   // bounded run length
   always @(posedge clock) begin
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         test_done();
      end
   end
   // main sequence: reset values, corners, random words, unmapped, second reset
   initial begin
      repeat (8) @(posedge clock);
      sys_rst <= 1'b0;
      capS = 1'b1;
      repeat (4) @(posedge clock);
      strap <= 1'b0; // captured strap must hold
      checkAll(32'h00050000);
      for (int i = 0; i < 4; i++) wrCheck(32'h00100000 | (i << 5) | ((i + 2) << 16));
      wrCheck(32'hFFFFFFFF);
      wrCheck(32'h0012FF90);
      for (int i = 0; i < 16; i++) begin
         d = $random(seed);
         d[ONE_BIT] = 1'b1;
         if (d[19:16] < 4'h2) d[19:16] = 4'h2;
         wrCheck(d);
      end
      apb(1'b1, RESERVED_HOLE, 32'h00000000);
      chk(err, 1'b1);
      apb(1'b0, 12'h078, 32'h0);
      chk({err, rd}, {1'b1, 32'h0});
      checkAll(d);
      sys_rst <= 1'b1;
      repeat (8) @(posedge clock);
      sys_rst <= 1'b0;
      capS = 1'b0;
      repeat (4) @(posedge clock);
      checkAll(32'h00050000);
      test_done();
   end
endmodule : hardware_config_register_test
